// file: urm_pkg.sv
// shared constants and carriers for the rs-485 / multidrop control block
// assumes a 9-bit character path (8 data bits plus address/ninth bit)
package urm_pkg;

    // line-control mode field codes
    localparam logic [2:0] MODE_ADDR_RX   = 3'h3;
    localparam logic [2:0] MODE_ADDR_RXTX = 3'h4;

    // pin-function field codes
    localparam logic [2:0] PIN_DE_TX      = 3'h3;
    localparam logic [2:0] PIN_DE_MATCH   = 3'h4;

    // field widths
    localparam int MODE_W  = 3;
    localparam int DLY_W   = 4;
    localparam int ADDR_W  = 8;

    // frame: start, 8 data, ninth bit, stop
    localparam int         FRAME_BITS     = 11;
    localparam logic [3:0] FRAME_LAST_BIT = 4'ha;

    // transmit buffer depth
    localparam int TX_FIFO_DEPTH = 16;

    // reset values
    localparam logic DE_PIN_RST = 1'h1;
    localparam logic LINE_IDLE  = 1'h1;

    typedef struct packed {
        logic              ninth;
        logic [ADDR_W-1:0] data;
    } urm_char_s;

    localparam int CHAR_W = $bits(urm_char_s);

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LEAD,
        TX_SHIFT,
        TX_HOLD
    } urm_tx_state_e;

endpackage

// file: urm_fifo.sv
// synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes depth is a power of two and both sides on sys_clk
`timescale 1ns/1ps
module urm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff  [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      nxt_wr_ptr;
    logic [AW:0]      rd_ptr_ff;
    logic [AW:0]      nxt_rd_ptr;
    logic             full;
    logic             empty;

    assign empty     = (wr_ptr_ff == rd_ptr_ff);
    assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

    always_comb begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (in_valid && !full) begin
            nxt_mem[wr_ptr_ff[AW-1:0]] = in_data;
            nxt_wr_ptr = wr_ptr_ff + 1'b1;
        end
        if (out_ready && !empty) begin
            nxt_rd_ptr = rd_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            mem_ff    <= nxt_mem;
        end
    end

endmodule

// file: urm_addr_match.sv
// classifies a received character and compares it to the two addresses
// assumes the character is presented with its ninth (or parity) bit
`timescale 1ns/1ps
module urm_addr_match (
    input  wire urm_pkg::urm_char_s         rx_char,
    input  wire logic [urm_pkg::ADDR_W-1:0] unicast_addr,
    input  wire logic [urm_pkg::ADDR_W-1:0] multicast_addr,
    output logic                            is_addr,
    output logic                            hit
);
    import urm_pkg::*;

    assign is_addr = rx_char.ninth;
    assign hit     = (rx_char.data == unicast_addr) || (rx_char.data == multicast_addr);

endmodule

// file: urm_rs485_ctrl.sv
// rs-485 driver-enable, turn-around delay, multidrop address gating, half duplex
// assumes bit_tick from the baud generator and a receive shift register outside
`timescale 1ns/1ps
module urm_rs485_ctrl #(
    parameter int FIFO_DEPTH = urm_pkg::TX_FIFO_DEPTH
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic [urm_pkg::MODE_W-1:0]  pin_mode,
    input  wire logic                        de_polarity,
    input  wire logic [urm_pkg::MODE_W-1:0]  line_mode,
    input  wire logic                        half_duplex,
    input  wire logic [urm_pkg::DLY_W-1:0]   turnaround_delay,
    input  wire logic [urm_pkg::ADDR_W-1:0]  unicast_addr,
    input  wire logic [urm_pkg::ADDR_W-1:0]  multicast_addr,
    input  wire logic                        bit_tick,
    input  wire logic                        tx_char_valid,
    output logic                             tx_char_ready,
    input  wire urm_pkg::urm_char_s          tx_char,
    output logic                             txd,
    output logic                             driver_enable_pin,
    output logic                             driver_enable_oe,
    input  wire logic                        rxd,
    output logic                             rxd_gated,
    input  wire logic                        rx_char_valid,
    input  wire urm_pkg::urm_char_s          rx_char,
    output logic                             rx_wr_valid,
    output logic [urm_pkg::ADDR_W-1:0]       rx_wr_data,
    output logic                             addr_match,
    output logic                             tx_active
);
    import urm_pkg::*;

    urm_tx_state_e         state_ff;
    urm_tx_state_e         nxt_state;
    logic [FRAME_BITS-1:0] shift_ff;
    logic [FRAME_BITS-1:0] nxt_shift;
    logic [3:0]            bit_cnt_ff;
    logic [3:0]            nxt_bit_cnt;
    logic [DLY_W-1:0]      hold_cnt_ff;
    logic [DLY_W-1:0]      nxt_hold_cnt;
    logic                  de_use_ff;
    logic                  nxt_de_use;
    logic                  de_on_ff;
    logic                  nxt_de_on;
    logic                  de_pin_ff;
    logic                  nxt_de_pin;
    logic                  txd_ff;
    logic                  nxt_txd;
    logic                  match_ff;
    logic                  nxt_match;
    logic                  rx_wr_valid_ff;
    logic                  nxt_rx_wr_valid;
    logic [ADDR_W-1:0]     rx_wr_data_ff;
    logic [ADDR_W-1:0]     nxt_rx_wr_data;
    logic                  rxd_gated_ff;
    logic                  nxt_rxd_gated;
    logic                  fifo_valid;
    logic [CHAR_W-1:0]     fifo_data;
    urm_char_s             fifo_char;
    logic                  tx_load;
    logic                  pin_auto;
    logic                  addr_mode;
    logic                  tx_enable;
    logic                  de_use_now;
    logic                  tx_busy;
    logic                  rx_block;
    logic                  is_addr;
    logic                  hit;

    urm_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (tx_char_valid),
        .in_ready  (tx_char_ready),
        .in_data   (tx_char),
        .out_valid (fifo_valid),
        .out_ready (tx_load),
        .out_data  (fifo_data)
    );

    urm_addr_match u_match (
        .rx_char        (rx_char),
        .unicast_addr   (unicast_addr),
        .multicast_addr (multicast_addr),
        .is_addr        (is_addr),
        .hit            (hit)
    );

    assign fifo_char = urm_char_s'(fifo_data);
    assign pin_auto  = (pin_mode == PIN_DE_TX) || (pin_mode == PIN_DE_MATCH);
    assign addr_mode = (line_mode == MODE_ADDR_RX) || (line_mode == MODE_ADDR_RXTX);
    assign tx_enable = (line_mode != MODE_ADDR_RXTX) || match_ff;
    // enable every frame or after match
    assign de_use_now = (pin_mode == PIN_DE_TX) || ((pin_mode == PIN_DE_MATCH) && match_ff);
    assign tx_busy   = (state_ff == TX_SHIFT);
    assign rx_block  = half_duplex && tx_busy;

    always_comb begin
        nxt_state    = state_ff;
        nxt_shift    = shift_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_de_use   = de_use_ff;
        tx_load      = 1'b0;
        unique case (state_ff)
            TX_IDLE: begin
                if (fifo_valid && tx_enable) begin
                    if (de_use_now) begin
                        nxt_state  = TX_LEAD;
                        nxt_de_use = 1'b1;
                    end else begin
                        nxt_de_use = 1'b0;
                        tx_load    = 1'b1;
                        nxt_state  = TX_SHIFT;
                    end
                end
            end
            TX_LEAD: begin
                if (!tx_enable) begin
                    nxt_state = TX_IDLE;
                end else if (bit_tick) begin
                    tx_load   = 1'b1;
                    nxt_state = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (bit_tick) begin
                    if (bit_cnt_ff == 4'h0) begin
                        if (fifo_valid && tx_enable) begin
                            tx_load = 1'b1;
                        end else if ((turnaround_delay == 4'h0) || !de_use_ff) begin
                            nxt_state = TX_IDLE;
                        end else begin
                            nxt_state    = TX_HOLD;
                            nxt_hold_cnt = turnaround_delay;
                        end
                    end else begin
                        nxt_shift   = {LINE_IDLE, shift_ff[FRAME_BITS-1:1]};
                        nxt_bit_cnt = bit_cnt_ff - 4'h1;
                    end
                end
            end
            TX_HOLD: begin
                if (fifo_valid && tx_enable) begin
                    tx_load   = 1'b1;
                    nxt_state = TX_SHIFT;
                end else if (bit_tick) begin
                    if (hold_cnt_ff == 4'h1) begin
                        nxt_state = TX_IDLE;
                    end else begin
                        nxt_hold_cnt = hold_cnt_ff - 4'h1;
                    end
                end
            end
        endcase
        if (tx_load) begin
            nxt_shift   = {LINE_IDLE, fifo_char.ninth, fifo_char.data, 1'b0};
            nxt_bit_cnt = FRAME_LAST_BIT;
        end
        nxt_de_on  = (nxt_state != TX_IDLE) && nxt_de_use;
        nxt_de_pin = nxt_de_on ~^ de_polarity;
        nxt_txd    = (nxt_state == TX_SHIFT) ? nxt_shift[0] : LINE_IDLE;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= TX_IDLE;
            shift_ff    <= '1;
            bit_cnt_ff  <= 4'h0;
            hold_cnt_ff <= 4'h0;
            de_use_ff   <= 1'b0;
            de_on_ff    <= 1'b0;
            de_pin_ff   <= DE_PIN_RST;
            txd_ff      <= LINE_IDLE;
        end else begin
            state_ff    <= nxt_state;
            shift_ff    <= nxt_shift;
            bit_cnt_ff  <= nxt_bit_cnt;
            hold_cnt_ff <= nxt_hold_cnt;
            de_use_ff   <= nxt_de_use;
            de_on_ff    <= nxt_de_on;
            de_pin_ff   <= nxt_de_pin;
            txd_ff      <= nxt_txd;
        end
    end

    always_comb begin
        nxt_match       = match_ff;
        nxt_rx_wr_valid = 1'b0;
        nxt_rx_wr_data  = rx_wr_data_ff;
        if (!addr_mode) begin
            nxt_match = 1'b0;
        end
        if (rx_char_valid && !rx_block) begin
            if (addr_mode && is_addr) begin
                nxt_match = hit;
            end else if (!addr_mode || match_ff) begin
                nxt_rx_wr_valid = 1'b1;
                nxt_rx_wr_data  = rx_char.data;
            end
        end
        nxt_rxd_gated = rx_block ? LINE_IDLE : rxd;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_ff       <= 1'b0;
            rx_wr_valid_ff <= 1'b0;
            rx_wr_data_ff  <= '0;
            rxd_gated_ff   <= LINE_IDLE;
        end else begin
            match_ff       <= nxt_match;
            rx_wr_valid_ff <= nxt_rx_wr_valid;
            rx_wr_data_ff  <= nxt_rx_wr_data;
            rxd_gated_ff   <= nxt_rxd_gated;
        end
    end

    assign txd               = txd_ff;
    assign driver_enable_pin = de_pin_ff;
    assign driver_enable_oe  = pin_auto;
    assign rxd_gated         = rxd_gated_ff;
    assign rx_wr_valid       = rx_wr_valid_ff;
    assign rx_wr_data        = rx_wr_data_ff;
    assign addr_match        = match_ff;
    assign tx_active         = tx_busy;

    property p_lead_needs_pin;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_IDLE && nxt_state == TX_LEAD) |-> pin_auto;
    endproperty
    a_lead_needs_pin: assert property (p_lead_needs_pin) else $error("lead phase without auto pin mode");
    property p_de_before_start;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_LEAD && nxt_state == TX_SHIFT) |-> de_on_ff ##1 (de_on_ff && txd_ff == 1'b0);
    endproperty
    a_de_before_start: assert property (p_de_before_start) else $error("start bit without prior enable");
    property p_zero_delay_release;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_SHIFT && nxt_state == TX_IDLE) |-> bit_tick && bit_cnt_ff == 4'h0
            && (turnaround_delay == 4'h0 || !de_use_ff) ##1 !de_on_ff;
    endproperty
    a_zero_delay_release: assert property (p_zero_delay_release) else $error("enable release mistimed");
    property p_pin_level;
        @(posedge sys_clk) disable iff (!rst_n)
        ($past(rst_n) && state_ff == TX_IDLE && $stable(de_polarity) && $past(state_ff == TX_IDLE))
            |-> de_pin_ff == !de_polarity;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("idle enable pin level wrong");
    property p_hold_load;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_SHIFT && nxt_state == TX_HOLD) |=> hold_cnt_ff == $past(turnaround_delay) && de_on_ff;
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("turn-around count not loaded");
    property p_match_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_char_valid && !rx_block && addr_mode && is_addr && hit) |=> match_ff && !rx_wr_valid_ff;
    endproperty
    a_match_set: assert property (p_match_set) else $error("address match not taken");
    property p_match_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_char_valid && !rx_block && addr_mode && is_addr && !hit) |=> !match_ff;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("address miss did not close receiver");
    property p_data_gated;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_char_valid && addr_mode && !is_addr && !match_ff) |=> !rx_wr_valid_ff;
    endproperty
    a_data_gated: assert property (p_data_gated) else $error("data written without match");
    property p_tx_mode4;
        @(posedge sys_clk) disable iff (!rst_n)
        (line_mode == MODE_ADDR_RXTX && !match_ff) |-> !tx_load;
    endproperty
    a_tx_mode4: assert property (p_tx_mode4) else $error("transmit without match in mode 4");
    property p_half_duplex;
        @(posedge sys_clk) disable iff (!rst_n)
        (half_duplex && tx_busy) |=> rxd_gated_ff && !rx_wr_valid_ff;
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("receive not ignored while sending");
    property p_cov_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_HOLD) ##1 (state_ff == TX_IDLE);
    endproperty
    c_cov_hold: cover property (p_cov_hold);
    property p_cov_match;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(match_ff) ##[1:200] rx_wr_valid_ff;
    endproperty
    c_cov_match: cover property (p_cov_match);
    property p_cov_back_to_back;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == TX_SHIFT && tx_load);
    endproperty
    c_cov_back_to_back: cover property (p_cov_back_to_back);

endmodule

// file: urm_xcvr_model.sv
// behavioural rs-485 transceiver: the block's driver onto a biased shared bus
// assumes de_polarity mirrors the polarity the block was given
`timescale 1ns/1ps
module urm_xcvr_model (
    input  wire logic txd,
    input  wire logic driver_enable_pin,
    input  wire logic de_polarity,
    output logic      bus_line,
    output logic      rxd
);
    logic drv_on;

    assign drv_on   = (driver_enable_pin === de_polarity);
    // fail-safe bias: an undriven bus settles to idle high
    assign bus_line = drv_on ? txd : 1'b1;
    // receiver always listens, so the block hears its own echo
    assign rxd      = bus_line;
endmodule

// file: test_uart_rs485_multidrop_control.sv
// self-checking bench for the rs-485 driver-enable and multidrop control block
// assumes a transceiver model on the far side and a bench-made bit tick every 8 clocks
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_uart_rs485_multidrop_control;
    import urm_pkg::*;
    logic            sys_clk = 1'b0;
    logic            rst_n, de_polarity, half_duplex, bit_tick, tx_char_valid, rx_char_valid;
    logic [2:0]      pin_mode, line_mode;
    logic [3:0]      turnaround_delay;
    logic [7:0]      unicast_addr, multicast_addr, rx_wr_data;
    urm_char_s       tx_char, rx_char;
    logic            tx_char_ready, txd, driver_enable_pin, driver_enable_oe, rxd, rxd_gated;
    logic            rx_wr_valid, addr_match, tx_active, bus_line, de_act, seen_tx;
    int              error_cnt, check_count, nb, de_off, de_on, hold, hd_leak, echo0, tick_div;
    logic [10:0]     sh;
    logic [10:0]     frm_q[$], exp_q[$];
    logic [3:0]      dly_tab[3] = '{4'h0, 4'h1, 4'hf};

    urm_rs485_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .pin_mode(pin_mode), .de_polarity(de_polarity),
        .line_mode(line_mode), .half_duplex(half_duplex), .turnaround_delay(turnaround_delay),
        .unicast_addr(unicast_addr), .multicast_addr(multicast_addr), .bit_tick(bit_tick),
        .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_char(tx_char), .txd(txd),
        .driver_enable_pin(driver_enable_pin), .driver_enable_oe(driver_enable_oe), .rxd(rxd),
        .rxd_gated(rxd_gated), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_wr_valid(rx_wr_valid),
        .rx_wr_data(rx_wr_data), .addr_match(addr_match), .tx_active(tx_active));
    urm_xcvr_model XCVR (.txd(txd), .driver_enable_pin(driver_enable_pin), .de_polarity(de_polarity),
        .bus_line(bus_line), .rxd(rxd));

    assign de_act = (driver_enable_pin === de_polarity);
    always #25 sys_clk = ~sys_clk;

    // baud generator stand-in
    always @(posedge sys_clk) begin
        #2;
        tick_div = (tick_div == 7) ? 0 : tick_div + 1;
        bit_tick = (tick_div == 0);
    end

    // line monitor: frames sampled at each tick, enable hold and echo counts
    always @(posedge sys_clk) begin
        if (bit_tick && tx_active) begin
            sh[nb] = txd;
            nb++;
            if (!de_act) de_off++;
            if (nb == FRAME_BITS) begin
                frm_q.push_back(sh);
                nb = 0;
            end
        end
        if (bit_tick && seen_tx && !tx_active && de_act) hold++;
        if (tx_active) seen_tx = 1'b1;
        if (de_act) de_on++;
        if (tx_active && rxd_gated === 1'b0) begin
            if (half_duplex) hd_leak++;
            else echo0++;
        end
    end

    task automatic finish_test;
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic clr_mon;
        nb = 0; de_off = 0; de_on = 0; hold = 0; hd_leak = 0; echo0 = 0; seen_tx = 1'b0;
        frm_q.delete();
        exp_q.delete();
    endtask

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #2;
    endtask

    // leaves valid high so back-to-back writes need no extra clock
    task automatic wr_char(input logic n, input logic [7:0] d);
        logic taken;
        tx_char = {n, d};
        tx_char_valid = 1'b1;
        taken = 1'b0;
        for (int i = 0; i < 5000 && !taken; i++) begin
            @(posedge sys_clk);
            taken = tx_char_ready;
        end
        #2;
        `CHK(taken, 1'b1)
        exp_q.push_back({1'b1, n, d, 1'b0});
    endtask

    task automatic rx_send(input logic n, input logic [7:0] d, input logic wr);
        rx_char = {n, d};
        rx_char_valid = 1'b1;
        @(posedge sys_clk);
        #2;
        `CHK(rx_wr_valid, wr)
        if (wr) `CHK(rx_wr_data, d)
        rx_char_valid = 1'b0;
        @(posedge sys_clk);
        #2;
    endtask

    task automatic wait_done(input int lim);
        int k;
        k = 0;
        while (k < lim && !(seen_tx && !tx_active && !de_act)) begin
            @(posedge sys_clk);
            #2;
            k++;
        end
        `CHK(k < lim, 1'b1)
    endtask

    task automatic chk_frames;
        `CHK(frm_q.size(), exp_q.size())
        foreach (exp_q[i]) if (i < frm_q.size()) `CHK(frm_q[i], exp_q[i])
    endtask

    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("[ERR] t=%0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        rst_n = 1'b0; pin_mode = PIN_DE_TX; de_polarity = 1'b1; line_mode = 3'h0; half_duplex = 1'b0;
        turnaround_delay = 4'h0; unicast_addr = 8'h21; multicast_addr = 8'h7e; bit_tick = 1'b0;
        tx_char_valid = 1'b0; tx_char = '0; rx_char_valid = 1'b0; rx_char = '0; tick_div = 0;
        error_cnt = 0; check_count = 0;
        clr_mon;
        repeat (6) @(posedge sys_clk);
        #2;
        `CHK({txd, driver_enable_pin, rxd_gated, tx_char_ready}, {LINE_IDLE, DE_PIN_RST, 2'b11})
        `CHK({tx_active, addr_match, rx_wr_valid}, 3'b000)
        repeat (6) @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        settle;
        `CHK(driver_enable_pin, ~de_polarity)
        for (int m = 0; m < 8; m++) begin
            pin_mode = m[2:0];
            #1;
            `CHK(driver_enable_oe, (m == 3 || m == 4))
        end
        pin_mode = PIN_DE_TX;
        // every transmission enables the driver; polarity and delay sweep
        for (int p = 0; p < 2; p++) begin
            for (int di = 0; di < 3; di++) begin
                de_polarity = p[0];
                turnaround_delay = dly_tab[di];
                settle;
                clr_mon;
                wr_char(di[0], 8'ha5 ^ di[7:0]);
                if (di == 2) wr_char(1'b1, 8'h3c);
                tx_char_valid = 1'b0;
                wait_done(2000);
                chk_frames;
                `CHK(de_off, 0)
                `CHK(hold, int'(turnaround_delay))
                `CHK(echo0 > 0, 1'b1)
            end
        end
        // receive-only address matching
        line_mode = MODE_ADDR_RX;
        settle;
        rx_send(1'b0, 8'h55, 1'b0);
        rx_send(1'b1, 8'h21, 1'b0);
        `CHK(addr_match, 1'b1)
        rx_send(1'b0, 8'h12, 1'b1);
        rx_send(1'b0, 8'h34, 1'b1);
        rx_send(1'b1, 8'h22, 1'b0);
        `CHK(addr_match, 1'b0)
        rx_send(1'b0, 8'h56, 1'b0);
        rx_send(1'b1, 8'h7e, 1'b0);
        `CHK(addr_match, 1'b1)
        rx_send(1'b0, 8'h9a, 1'b1);
        line_mode = 3'h0;
        settle;
        rx_send(1'b1, 8'h21, 1'b1);
        `CHK(addr_match, 1'b0)
        // mode 4: transmitter held until a match, buffer filled, half duplex drop
        line_mode = MODE_ADDR_RXTX;
        pin_mode = PIN_DE_MATCH;
        half_duplex = 1'b1;
        turnaround_delay = 4'h0;
        de_polarity = 1'b1;
        rx_send(1'b1, 8'h99, 1'b0);
        settle;
        clr_mon;
        for (int i = 0; i < TX_FIFO_DEPTH; i++) wr_char(1'b0, i[7:0]);
        `CHK(tx_char_ready, 1'b0)
        tx_char = 9'h1ff;
        @(posedge sys_clk);
        #2;
        tx_char_valid = 1'b0;
        repeat (40) @(posedge sys_clk);
        #2;
        `CHK(seen_tx, 1'b0)
        rx_send(1'b1, 8'h21, 1'b0);
        repeat (40) @(posedge sys_clk);
        #2;
        `CHK(tx_active, 1'b1)
        rx_send(1'b0, 8'h77, 1'b0);
        wait_done(4000);
        chk_frames;
        `CHK(hd_leak, 0)
        `CHK(de_off, 0)
        // mode 3 transmits without a match; pin code 4 keeps the driver off
        line_mode = MODE_ADDR_RX;
        half_duplex = 1'b0;
        rx_send(1'b1, 8'h40, 1'b0);
        `CHK(addr_match, 1'b0)
        settle;
        clr_mon;
        wr_char(1'b0, 8'hc3);
        tx_char_valid = 1'b0;
        wait_done(2000);
        chk_frames;
        `CHK(de_on, 0)
        finish_test;
    end
endmodule
